// *** hw/tws_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module tws_master (
  input wire logic core_clk, // Core clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic scl_i, // SCL wire level
  output logic scl_o, // SCL output value
  output logic scl_oe, // SCL pull-low enable
  input wire logic sda_i, // SDA wire level
  output logic sda_o, // SDA output value
  output logic sda_oe // SDA pull-low enable
);
  import tws_pkg::*;
  tws_state_t s_ff;
  tws_state_t nxt_s;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic run;
  logic adv;
  logic wait_hi;
  logic rxd;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic [7:0] cntn;
  ////////////////////////////////////////////////////////////////////////////
  // Bus inputs come from another domain
  tws_sync2 u_scl_sync (
    .clk(core_clk),
    .rst(sys_rst),
    .d(scl_i),
    .q(scl_s)
  );
  tws_sync2 u_sda_sync (
    .clk(core_clk),
    .rst(sys_rst),
    .d(sda_i),
    .q(sda_s)
  );
  tws_tick u_tick (
    .clk(core_clk),
    .rst(sys_rst),
    .run(run),
    .div(s_ff.div),
    .tick(tick)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Stepping; a stretched SCL holds the high quarter until the wire rises
  assign run = (s_ff.st == ST_STA) || (s_ff.st == ST_BITS) || (s_ff.st == ST_STO);
  assign wait_hi = (s_ff.st == ST_STA) ? (s_ff.q == 2'd1) : (s_ff.q == 2'd2);
  assign adv = tick && !(wait_hi && !scl_s);
  assign rxd = s_ff.rd && (s_ff.ph == PH_DAT);
  assign cntn = (s_ff.ph == PH_DAT) ? s_ff.cnt - 8'h01 : s_ff.cnt;
  // APB decode
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = (paddr == `TWS_OFF_CTRL) || (paddr == `TWS_OFF_ADDR)
    || (paddr == `TWS_OFF_LEN) || (paddr == `TWS_OFF_TX) || (paddr == `TWS_OFF_RX)
    || (paddr == `TWS_OFF_STAT) || (paddr == `TWS_OFF_DIV);
  ////////////////////////////////////////////////////////////////////////////
  // Next state: register side first, then the bit engine, then the TX refill
  always_comb
  begin
    nxt_s = s_ff;
    // Read data latched in setup so the access phase sees a flop
    if (psel && !penable && !pwrite)
    begin
      if (paddr == `TWS_OFF_CTRL)
        nxt_s.prd = {28'h000_0000, s_ff.hold, s_ff.rd, s_ff.ten, 1'b0};
      else if (paddr == `TWS_OFF_ADDR)
        nxt_s.prd = {22'h00_0000, s_ff.addr};
      else if (paddr == `TWS_OFF_LEN)
        nxt_s.prd = {24'h00_0000, s_ff.len};
      else if (paddr == `TWS_OFF_TX)
        nxt_s.prd = {24'h00_0000, s_ff.txb};
      else if (paddr == `TWS_OFF_RX)
        nxt_s.prd = {24'h00_0000, s_ff.rxb};
      else if (paddr == `TWS_OFF_STAT)
        nxt_s.prd = {27'h000_0000, (s_ff.st == ST_HOLD) || (s_ff.st == ST_WAIT),
          s_ff.txf, s_ff.rxv, s_ff.nak, s_ff.st != ST_IDLE};
      else if (paddr == `TWS_OFF_DIV)
        nxt_s.prd = {16'h0000, s_ff.div};
      else
        nxt_s.prd = 32'h0000_0000;
    end
    // Clears come before the engine so a same-cycle set wins
    if (rd_acc && paddr == `TWS_OFF_RX)
      nxt_s.rxv = 1'b0;
    if (wr_acc && paddr == `TWS_OFF_STAT && pwdata[`TWS_ST_NAK])
      nxt_s.nak = 1'b0;
    if (wr_acc && paddr == `TWS_OFF_DIV)
      nxt_s.div = pwdata[15:0];
    // Setup only between transfers, so a frame never sees it change
    if (wr_acc && (s_ff.st == ST_IDLE || s_ff.st == ST_HOLD))
    begin
      if (paddr == `TWS_OFF_ADDR)
        nxt_s.addr = pwdata[9:0];
      else if (paddr == `TWS_OFF_LEN)
        nxt_s.len = pwdata[7:0];
      else if (paddr == `TWS_OFF_CTRL)
      begin
        nxt_s.ten = pwdata[`TWS_CTL_TEN];
        nxt_s.rd = pwdata[`TWS_CTL_RD];
        nxt_s.hold = pwdata[`TWS_CTL_HOLD];
        if (pwdata[`TWS_CTL_GO])
        begin
          // From HOLD this start is a RESTART
          nxt_s.st = ST_STA;
          nxt_s.q = 2'd0;
          nxt_s.ph = PH_A1;
          nxt_s.a2d = 1'b0;
          nxt_s.cnt = s_ff.len;
          nxt_s.sda_oe = 1'b0;
          if (pwdata[`TWS_CTL_TEN])
            nxt_s.sh = {`TWS_A10_MARK, s_ff.addr[9:8], 1'b0};
          else
            nxt_s.sh = {s_ff.addr[6:0], pwdata[`TWS_CTL_RD]};
        end
        else if (pwdata[`TWS_CTL_STOP] && s_ff.st == ST_HOLD)
        begin
          nxt_s.st = ST_STO;
          nxt_s.q = 2'd0;
        end
      end
    end
    // Bit engine, one quarter per tick
    case (s_ff.st)
      ST_STA:
        if (adv)
        begin
          nxt_s.q = s_ff.q + 2'd1;
          if (s_ff.q == 2'd0)
            nxt_s.scl_oe = 1'b0;
          else if (s_ff.q == 2'd1)
            nxt_s.sda_oe = 1'b1;
          else if (s_ff.q == 2'd2)
            nxt_s.scl_oe = 1'b1;
          else
          begin
            nxt_s.st = ST_BITS;
            nxt_s.bitn = 4'd0;
          end
        end
      ST_BITS:
        if (adv)
        begin
          nxt_s.q = s_ff.q + 2'd1;
          if (s_ff.q == 2'd0)
          begin
            // Data set up while SCL is low
            if (s_ff.bitn < 4'd8)
              nxt_s.sda_oe = !rxd && !s_ff.sh[7];
            else
              nxt_s.sda_oe = rxd && (s_ff.cnt != 8'h01);
          end
          else if (s_ff.q == 2'd1)
            nxt_s.scl_oe = 1'b0;
          else if (s_ff.q == 2'd3)
          begin
            nxt_s.scl_oe = 1'b1;
            if (s_ff.bitn < 4'd8)
            begin
              // Sampled late in the high phase
              nxt_s.sh = {s_ff.sh[6:0], sda_s};
              nxt_s.bitn = s_ff.bitn + 4'd1;
            end
            else
            begin
              nxt_s.bitn = 4'd0;
              if (rxd)
              begin
                nxt_s.rxb = s_ff.sh;
                nxt_s.rxv = 1'b1;
              end
              if (!rxd && sda_s)
              begin
                // No acknowledge: abandon with STOP
                nxt_s.nak = 1'b1;
                nxt_s.st = ST_STO;
              end
              else if (s_ff.ph == PH_A1 && s_ff.ten && !s_ff.a2d)
              begin
                nxt_s.ph = PH_A2;
                nxt_s.sh = s_ff.addr[7:0];
              end
              else if (s_ff.ph == PH_A2 && s_ff.rd)
              begin
                // 10-bit read turns round with RESTART
                nxt_s.st = ST_STA;
                nxt_s.q = 2'd0;
                nxt_s.a2d = 1'b1;
                nxt_s.ph = PH_A1;
                nxt_s.sda_oe = 1'b0;
                nxt_s.sh = {`TWS_A10_MARK, s_ff.addr[9:8], 1'b1};
              end
              else
              begin
                nxt_s.ph = PH_DAT;
                nxt_s.cnt = cntn;
                if (cntn == 8'h00)
                  nxt_s.st = s_ff.hold ? ST_HOLD : ST_STO;
                else if (!s_ff.rd && s_ff.txf)
                begin
                  nxt_s.sh = s_ff.txb;
                  nxt_s.txf = 1'b0;
                end
                else if (!s_ff.rd)
                  nxt_s.st = ST_WAIT;
              end
            end
          end
        end
      ST_WAIT:
        // SCL stays low until software refills
        if (s_ff.txf)
        begin
          nxt_s.sh = s_ff.txb;
          nxt_s.txf = 1'b0;
          nxt_s.st = ST_BITS;
          nxt_s.q = 2'd0;
        end
      ST_STO:
        if (adv)
        begin
          nxt_s.q = s_ff.q + 2'd1;
          if (s_ff.q == 2'd0)
            nxt_s.sda_oe = 1'b1;
          else if (s_ff.q == 2'd1)
            nxt_s.scl_oe = 1'b0;
          else if (s_ff.q == 2'd2)
            nxt_s.sda_oe = 1'b0;
          else
            nxt_s.st = ST_IDLE;
        end
      default:
      begin
      end
    endcase
    // Refill after the engine so a new byte is never lost
    if (wr_acc && paddr == `TWS_OFF_TX)
    begin
      nxt_s.txb = pwdata[7:0];
      nxt_s.txf = 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_ff <= '0;
      s_ff.div <= 16'(`TWS_QTR_STD);
    end
    else
      s_ff <= nxt_s;
  end
  // Open-drain pins: only ever pull low or release
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = s_ff.scl_oe;
  assign sda_oe = s_ff.sda_oe;
  assign prdata = s_ff.prd;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence ack_end_s;
    s_ff.st == ST_BITS && s_ff.bitn == 4'd8 && s_ff.q == 2'd3 && adv;
  endsequence
  sequence go_s;
    wr_acc && paddr == `TWS_OFF_CTRL && pwdata[`TWS_CTL_GO] && s_ff.st == ST_IDLE;
  endsequence
  data_stable_a: assert property (($changed(sda_oe) && !$past(scl_oe))
    |-> (s_ff.st == ST_STA || s_ff.st == ST_STO || s_ff.st == ST_IDLE))
    else $error("SDA moved while SCL released outside a condition");
  start_edge_a: assert property (($rose(sda_oe) && !scl_oe) |-> s_ff.st == ST_STA)
    else $error("SDA fell with SCL high outside START");
  stop_edge_a: assert property (($fell(sda_oe) && !scl_oe) |-> s_ff.st == ST_STO)
    else $error("SDA rose with SCL high outside STOP");
  msb_first_a: assert property ((s_ff.st == ST_BITS && s_ff.q == 2'd1
    && s_ff.bitn < 4'd8 && !rxd) |-> sda_oe == !s_ff.sh[7])
    else $error("Transmitted bit is not the top bit of the shifter");
  nine_bits_a: assert property ((s_ff.st == ST_BITS && s_ff.q == 2'd3 && adv)
    |=> (s_ff.bitn == 4'd0) || ($past(s_ff.bitn) < 4'd8 && s_ff.bitn == $past(s_ff.bitn) + 4'd1))
    else $error("Bit count does not wrap after nine pulses");
  nak_stop_a: assert property ((ack_end_s and (!rxd && sda_s))
    |=> s_ff.st == ST_STO && s_ff.nak)
    else $error("Missing acknowledge did not lead to STOP");
  last_nak_a: assert property ((s_ff.st == ST_BITS && s_ff.q == 2'd1
    && s_ff.bitn == 4'd8 && rxd) |-> sda_oe == (s_ff.cnt != 8'h01))
    else $error("Read acknowledge wrong for this byte");
  end_by_stop_a: assert property ($rose(s_ff.st == ST_IDLE) |-> $past(s_ff.st) == ST_STO)
    else $error("Transfer ended without STOP");
  addr7_a: assert property ((go_s and !pwdata[`TWS_CTL_TEN])
    |=> s_ff.sh == {s_ff.addr[6:0], s_ff.rd} ##1 s_ff.st == ST_STA)
    else $error("7-bit address byte malformed");
  addr10_a: assert property ((go_s and pwdata[`TWS_CTL_TEN])
    |=> s_ff.sh[7:3] == `TWS_A10_MARK && s_ff.sh[2:1] == s_ff.addr[9:8] && !s_ff.sh[0])
    else $error("10-bit first byte malformed");
endmodule : tws_master
`default_nettype wire

// *** inc/tws_consts.svh ***
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
// Register byte offsets
`define TWS_OFF_CTRL 8'h00
`define TWS_OFF_ADDR 8'h04
`define TWS_OFF_LEN 8'h08
`define TWS_OFF_TX 8'h0C
`define TWS_OFF_RX 8'h10
`define TWS_OFF_STAT 8'h14
`define TWS_OFF_DIV 8'h18
// Control field positions
`define TWS_CTL_GO 0
`define TWS_CTL_TEN 1
`define TWS_CTL_RD 2
`define TWS_CTL_HOLD 3
`define TWS_CTL_STOP 4
// Status field positions
`define TWS_ST_BUSY 0
`define TWS_ST_NAK 1
`define TWS_ST_RXV 2
`define TWS_ST_TXF 3
`define TWS_ST_HELD 4
// First-byte marker of a 10-bit address
`define TWS_A10_MARK 5'h1E
// Timing: quarter bit period at standard rate, rounded down
`define TWS_CLK_HZ 40000000
`define TWS_STD_BPS 100000
`define TWS_QTR_STD (`TWS_CLK_HZ / (4 * `TWS_STD_BPS))
`endif

// *** inc/tws_pkg.sv ***
`default_nettype none
`include "tws_consts.svh"
package tws_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_STA, ST_BITS, ST_STO, ST_WAIT, ST_HOLD} tws_st_t;
  typedef enum logic [1:0] {PH_A1, PH_A2, PH_DAT} tws_ph_t;
  typedef struct packed {
    logic m;
    logic s;
  } tws_sync_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tws_tick_t;
  typedef struct packed {
    tws_st_t st;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    tws_ph_t ph;
    logic rd;
    logic ten;
    logic hold;
    logic a2d;
    logic [7:0] cnt;
    logic scl_oe;
    logic sda_oe;
    logic [9:0] addr;
    logic [7:0] len;
    logic [15:0] div;
    logic [7:0] txb;
    logic txf;
    logic [7:0] rxb;
    logic rxv;
    logic nak;
    logic [31:0] prd;
  } tws_state_t;
endpackage : tws_pkg
`default_nettype wire

// *** hw/tws_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module tws_sync2 (
  input wire logic clk, // Sampling clock
  input wire logic rst, // Synchronous reset
  input wire logic d, // Asynchronous level
  output logic q // Synchronised level
);
  import tws_pkg::*;
  tws_sync_t s_ff;
  tws_sync_t nxt_s;
  // Two-stage chain; only the second stage is read
  always_comb
  begin
    nxt_s.m = d;
    nxt_s.s = s_ff.m;
  end
  // Bus idles high, so reset to released level
  always_ff @(posedge clk)
  begin
    if (rst)
      s_ff <= 2'b11;
    else
      s_ff <= nxt_s;
  end
  assign q = s_ff.s;
endmodule : tws_sync2
`default_nettype wire

// *** hw/tws_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module tws_tick (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic run, // Count while high
  input wire logic [15:0] div, // Quarter period in cycles
  output logic tick // One-cycle pulse per quarter
);
  import tws_pkg::*;
  tws_tick_t s_ff;
  tws_tick_t nxt_s;
  // Reload on expiry; a zero divide is treated as one
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (!run)
      nxt_s.cnt = 16'h0000;
    else if (s_ff.cnt + 16'h0001 >= div)
    begin
      nxt_s.cnt = 16'h0000;
      nxt_s.tick = 1'b1;
    end
    else
      nxt_s.cnt = s_ff.cnt + 16'h0001;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end
  assign tick = s_ff.tick;
endmodule : tws_tick
`default_nettype wire

// *** tb/tws_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tws_slave_model #(
  parameter logic [6:0] SA7 = 7'h52, // 7-bit address
  parameter logic [9:0] SA10 = 10'h2C5, // 10-bit address
  parameter logic [7:0] RD_BASE = 8'h3C // First byte returned on reads
) (
  input wire logic scl, // SCL wire level
  input wire logic sda, // SDA wire level
  input wire logic stretch, // Hold SCL low before each read byte
  output logic scl_pull, // SCL pull-low, never drives high
  output logic sda_pull // SDA pull-low, never drives high
);
  // Mode: 0 idle, 1 first address, 2 second address, 3 write, 4 read
  int mode, pend, bitc, n_start, n_stop, n_mack, n_mnak, n_wr, n_rd;
  logic [7:0] rx, tx;
  logic [7:0] wlog [0:7];
  logic ten_ok, ack;

  //////////////////////////////////////////////////////////////////////
  // Released lines float to the pull-up level; never contends as a master
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    ten_ok = 1'b0;
  end

  // SDA edges with SCL high are bus conditions, never data
  always @(negedge sda)
  begin
    if (scl)
    begin
      n_start++;
      mode = 1;
      bitc = -1;
      sda_pull = 1'b0;
    end
  end
  always @(posedge sda)
  begin
    if (scl)
    begin
      n_stop++;
      mode = 0;
      ten_ok = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sample in the high phase; master ack seen on the ninth pulse
  always @(posedge scl)
  begin
    if (mode != 0 && bitc >= 0 && bitc < 8)
      rx = {rx[6:0], sda};
    else if (mode == 4 && bitc == 8)
    begin
      if (sda)
      begin
        n_mnak++;
        mode = 0;
      end
      else
        n_mack++;
    end
  end

  // Drive only while SCL is low; decide ack after the eighth bit
  always @(negedge scl)
  begin
    if (mode != 0 && bitc == 7)
    begin
      bitc = 8;
      ack = 1'b0;
      pend = mode;
      if (mode == 1 && rx[7:3] == 5'b11110 && rx[2:1] == SA10[9:8])
      begin
        ack = !rx[0] || ten_ok;
        pend = rx[0] ? 4 : 2;
      end
      else if (mode == 1 && rx[7:1] == SA7)
      begin
        ack = 1'b1;
        pend = rx[0] ? 4 : 3;
      end
      else if (mode == 1 && rx == 8'h00)
      begin
        // General call: take the following bytes as written data
        ack = 1'b1;
        pend = 3;
      end
      else if (mode == 2 && rx == SA10[7:0])
      begin
        ack = 1'b1;
        ten_ok = 1'b1;
        pend = 3;
      end
      else if (mode == 3)
      begin
        ack = 1'b1;
        wlog[n_wr] = rx;
        n_wr++;
      end
      sda_pull = ack;
      if (!ack && mode < 3)
        mode = 0;
    end
    else if (mode != 0 && bitc == 8)
    begin
      bitc = 0;
      mode = pend;
      sda_pull = 1'b0;
      if (mode == 4)
      begin
        tx = RD_BASE + 8'(n_rd);
        n_rd++;
        sda_pull = ~tx[7];
        // Stall the master as a slave without data would
        if (stretch)
        begin
          scl_pull = 1'b1;
          #2000;
          scl_pull = 1'b0;
        end
      end
    end
    else if (mode != 0)
    begin
      bitc++;
      if (mode == 4)
        sda_pull = ~tx[7 - bitc];
    end
  end
endmodule : tws_slave_model
`default_nettype wire

// *** tb/tws_master_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tws_consts.svh"
module tws_master_tb;
  localparam logic [6:0] SA7 = 7'h52;
  localparam logic [9:0] SA10 = 10'h2C5;
  localparam logic [7:0] RDB = 8'h3C;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, stretch;
  logic scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_mismatch, samples_checked;
  wire scl;
  wire sda;

  // Open-drain wires with pull-ups
  assign scl = !(scl_oe | scl_pull);
  assign sda = !(sda_oe | sda_pull);

  always #12.5 core_clk = ~core_clk;

  tws_master uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));
  tws_slave_model #(.SA7(SA7), .SA10(SA10), .RD_BASE(RDB)) m (.scl(scl), .sda(sda),
    .stretch(stretch), .scl_pull(scl_pull), .sda_pull(sda_pull));

  //////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask : chk

  // Setup cycle, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 64);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      chk(32'h0, 32'h1, "no pready");
      complete_run();
    end
  endtask : apb

  // Poll one status bit; bounded so a hang ends the run
  task automatic wait_st(input int b, input logic v);
    for (int k = 0; k < 3000; k++)
    begin
      apb(1'b0, `TWS_OFF_STAT, 32'h0);
      if (rd[b] === v)
        return;
    end
    chk(32'h0, 32'h1, "status wait");
    complete_run();
  endtask : wait_st

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stretch = 1'b0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    // Power-up edges of the wires are not bus traffic
    m.n_start = 0;
    m.n_stop = 0;
    apb(1'b0, `TWS_OFF_STAT, 32'h0);
    chk(rd, 32'h0, "stat reset");
    chk(32'(err), 32'h0, "mapped err");
    chk(32'({scl_o, sda_o}), 32'h0, "pins pull only");
    apb(1'b0, `TWS_OFF_DIV, 32'h0);
    chk(rd, 32'h64, "div reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(err), 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, `TWS_OFF_DIV, 32'h4);
    apb(1'b0, `TWS_OFF_DIV, 32'h0);
    chk(rd, 32'h4, "div write");
    $display("test registers done");
    // 7-bit write of two bytes, second byte late so SCL is stalled
    apb(1'b1, `TWS_OFF_ADDR, 32'(SA7));
    apb(1'b1, `TWS_OFF_LEN, 32'h2);
    apb(1'b1, `TWS_OFF_TX, 32'hC9);
    apb(1'b1, `TWS_OFF_CTRL, 32'h1);
    wait_st(4, 1'b1);
    chk(32'(scl), 32'h0, "scl stalled");
    chk(32'(m.n_stop), 32'h0, "no stop on empty");
    apb(1'b1, `TWS_OFF_TX, 32'h36);
    wait_st(0, 1'b0);
    chk(rd, 32'h0, "stat after write");
    chk(32'(m.wlog[0]), 32'hC9, "write byte 0");
    chk(32'(m.wlog[1]), 32'h36, "write byte 1");
    chk(32'(m.n_stop), 32'h1, "stop count");
    $display("test write7 done");
    // 7-bit read of three bytes with the slave stretching
    stretch <= 1'b1;
    apb(1'b1, `TWS_OFF_LEN, 32'h3);
    apb(1'b1, `TWS_OFF_CTRL, 32'h5);
    for (int i = 0; i < 3; i++)
    begin
      wait_st(2, 1'b1);
      apb(1'b0, `TWS_OFF_RX, 32'h0);
      chk(rd, 32'(RDB) + i, "read byte");
    end
    wait_st(0, 1'b0);
    chk(32'(m.n_mack), 32'h2, "master acks");
    chk(32'(m.n_mnak), 32'h1, "master nak");
    $display("test read7 done");
    // 10-bit write then 10-bit read with RESTART
    stretch <= 1'b0;
    apb(1'b1, `TWS_OFF_ADDR, 32'(SA10));
    apb(1'b1, `TWS_OFF_LEN, 32'h1);
    apb(1'b1, `TWS_OFF_TX, 32'h5A);
    apb(1'b1, `TWS_OFF_CTRL, 32'h3);
    wait_st(0, 1'b0);
    chk(32'(m.wlog[2]), 32'h5A, "write10 byte");
    apb(1'b1, `TWS_OFF_CTRL, 32'h7);
    wait_st(2, 1'b1);
    apb(1'b0, `TWS_OFF_RX, 32'h0);
    chk(rd, 32'(RDB) + 3, "read10 byte");
    wait_st(0, 1'b0);
    chk(32'(m.n_start), 32'h5, "start count");
    $display("test ten bit done");
    // Reserved CBUS address is refused: NAK then STOP
    apb(1'b1, `TWS_OFF_ADDR, 32'h1);
    apb(1'b1, `TWS_OFF_CTRL, 32'h1);
    wait_st(0, 1'b0);
    chk(rd, 32'h2, "nak status");
    chk(32'(m.n_stop), 32'h5, "stop after nak");
    apb(1'b1, `TWS_OFF_STAT, 32'h2);
    apb(1'b0, `TWS_OFF_STAT, 32'h0);
    chk(rd, 32'h0, "nak cleared");
    $display("test nak done");
    // Write ending in hold, then read by RESTART in the other direction
    apb(1'b1, `TWS_OFF_ADDR, 32'(SA7));
    apb(1'b1, `TWS_OFF_TX, 32'h81);
    apb(1'b1, `TWS_OFF_CTRL, 32'h9);
    wait_st(4, 1'b1);
    chk(32'(m.n_stop), 32'h5, "no stop in hold");
    chk(32'(scl), 32'h0, "scl held");
    apb(1'b1, `TWS_OFF_CTRL, 32'h5);
    wait_st(2, 1'b1);
    apb(1'b0, `TWS_OFF_RX, 32'h0);
    chk(rd, 32'(RDB) + 4, "combined read");
    wait_st(0, 1'b0);
    chk(32'(m.wlog[3]), 32'h81, "combined write");
    chk(32'(m.n_start), 32'h8, "restart count");
    chk(32'(m.n_stop), 32'h6, "final stop");
    $display("test combined done");
    // General call write; setup writes while busy are refused
    apb(1'b1, `TWS_OFF_ADDR, 32'h0);
    apb(1'b1, `TWS_OFF_TX, 32'hA7);
    apb(1'b1, `TWS_OFF_CTRL, 32'h1);
    apb(1'b1, `TWS_OFF_LEN, 32'h7);
    apb(1'b0, `TWS_OFF_LEN, 32'h0);
    chk(rd, 32'h1, "len kept while busy");
    wait_st(0, 1'b0);
    chk(rd, 32'h0, "stat general call");
    chk(32'(m.wlog[4]), 32'hA7, "general call byte");
    $display("test general call done");
    // Write left in hold, then ended by the STOP command alone
    apb(1'b1, `TWS_OFF_ADDR, 32'(SA7));
    apb(1'b0, `TWS_OFF_ADDR, 32'h0);
    chk(rd, 32'(SA7), "addr readback");
    apb(1'b1, `TWS_OFF_TX, 32'h18);
    apb(1'b1, `TWS_OFF_CTRL, 32'h9);
    apb(1'b0, `TWS_OFF_CTRL, 32'h0);
    chk(rd, 32'h8, "ctrl readback");
    wait_st(4, 1'b1);
    chk(32'(m.n_stop), 32'h7, "no stop yet");
    apb(1'b1, `TWS_OFF_CTRL, 32'h10);
    wait_st(0, 1'b0);
    chk(32'(m.wlog[5]), 32'h18, "held write byte");
    chk(32'(m.n_stop), 32'h8, "stop on command");
    $display("test stop command done");
    complete_run();
  end
endmodule : tws_master_tb
`default_nettype wire
